// >>> ohb_pkg.sv
`default_nettype none

package ohb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus geometry.
    localparam int NCH = 8;
    localparam int NREG = 16;
    localparam int DW = 8;
    localparam int AW = 8;
    localparam int IDX_LSB = 0;
    localparam int IDX_W = 4;
    localparam int CH_LSB = 4;
    localparam int CH_W = 3;
    localparam int GLB_BIT = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel register indices.
    localparam logic [3:0] IDX_IER = 4'h1;
    localparam logic [3:0] IDX_MCR = 4'h4;
    localparam logic [3:0] IDX_MSR = 4'h6;
    localparam logic [3:0] IDX_FEATURE_CONTROL_REG = 4'h8;
    localparam logic [3:0] IDX_EFR = 4'h9;

    // Global register indices.
    localparam logic [3:0] GIDX_IRQ = 4'h0;
    localparam logic [3:0] GIDX_SCRATCH = 4'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_SEL = 2;
    localparam int MCR_IR = 6;
    localparam int FEATURE_CONTROL_REG_HYST_LSB = 0;
    localparam int FEATURE_CONTROL_REG_RXINV = 4;
    localparam int FEATURE_CONTROL_REG_HDX = 5;
    localparam int EFR_ARTS = 6;
    localparam int EFR_ACTS = 7;
    localparam int IER_RTS_EV = 6;
    localparam int IER_CTS_EV = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic PIN_HIGH = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle states, Gray coded along idle, read or write, idle.
    typedef enum logic [1:0] {
        OHB_IDLE = 2'b00,
        OHB_READ = 2'b01,
        OHB_WRITE = 2'b10
    } ohb_state_t;

endpackage

`default_nettype wire

// >>> ohb_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ohb_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Only the second stage is visible; the first may be metastable.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= RST;
            sync_q <= RST;
        end else if (i_ce) begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

`default_nettype wire

// >>> ohb_chan.sv
`timescale 1ns/1ps
`default_nettype none

module ohb_chan (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [7:0] i_ier,
    input wire logic [7:0] i_mcr,
    input wire logic [7:0] i_feature_control_reg,
    input wire logic [7:0] i_efr,
    input wire logic i_serial_in,
    input wire logic i_clear_send_n,
    input wire logic i_set_ready_n,
    input wire logic i_carrier_detect_n,
    input wire logic i_ring_indicate_n,
    input wire logic i_tx_data,
    input wire logic i_tx_ir,
    input wire logic i_tx_busy,
    input wire logic i_rx_stop,
    input wire logic i_msr_clr,
    output logic o_serial_out,
    output logic o_request_send_n,
    output logic o_terminal_ready_n,
    output logic o_rx_line,
    output logic o_tx_allow,
    output logic o_flow_evt,
    output logic [7:0] o_msr
);
    import ohb_pkg::*;

    logic tx_q, rts_q, dtr_q, rx_q, allow_q, evt_q;
    logic [3:0] gp_q, delta_q;
    logic [3:0] gp_now;
    logic ir_mode, dsr_sel, gate_n, rts_d, dtr_d;

    assign ir_mode = i_mcr[MCR_IR];
    assign dsr_sel = i_mcr[MCR_SEL];
    assign gp_now = {~i_carrier_detect_n, ~i_ring_indicate_n, ~i_set_ready_n, ~i_clear_send_n};

    ////////////////////////////////////////////////////////////////////////////
    // Half-duplex takes priority over auto flow control, which overrides manual only while the manual bit is set.
    always_comb begin
        rts_d = ~i_mcr[MCR_RTS];
        dtr_d = ~i_mcr[MCR_DTR];
        if (i_feature_control_reg[FEATURE_CONTROL_REG_HDX]) begin
            if (dsr_sel) begin
                dtr_d = ~i_tx_busy;
            end else begin
                rts_d = ~i_tx_busy;
            end
        end else if (i_efr[EFR_ARTS]) begin
            if (dsr_sel && i_mcr[MCR_DTR]) begin
                dtr_d = i_rx_stop;
            end else if (!dsr_sel && i_mcr[MCR_RTS]) begin
                rts_d = i_rx_stop;
            end
        end
    end

    assign gate_n = dsr_sel ? i_set_ready_n : i_clear_send_n;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_q <= PIN_HIGH;
            rts_q <= PIN_HIGH;
            dtr_q <= PIN_HIGH;
            rx_q <= PIN_HIGH;
            allow_q <= 1'b1;
        end else if (i_ce) begin
            tx_q <= ir_mode ? i_tx_ir : i_tx_data;
            rts_q <= rts_d;
            dtr_q <= dtr_d;
            // Idle line reads high in normal mode.
            rx_q <= (ir_mode && i_feature_control_reg[FEATURE_CONTROL_REG_RXINV]) ? ~i_serial_in : i_serial_in;
            allow_q <= ~i_efr[EFR_ACTS] | ~gate_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // General purpose inputs with change flags; a change in the clearing cycle wins.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gp_q <= 4'h0;
            delta_q <= 4'h0;
            evt_q <= 1'b0;
        end else if (i_ce) begin
            gp_q <= gp_now;
            delta_q <= ((i_msr_clr) ? 4'h0 : delta_q) | (gp_q ^ gp_now);
            evt_q <= (i_msr_clr ? 1'b0 : evt_q)
                | (i_ier[IER_RTS_EV] & (rts_q ^ rts_d))
                | (i_ier[IER_CTS_EV] & i_efr[EFR_ACTS] & (gp_q[0] ^ gp_now[0]));
        end
    end

    assign o_serial_out = tx_q;
    assign o_request_send_n = rts_q;
    assign o_terminal_ready_n = dtr_q;
    assign o_rx_line = rx_q;
    assign o_tx_allow = allow_q;
    assign o_flow_evt = evt_q;
    assign o_msr = {gp_q, delta_q};

endmodule

`default_nettype wire

// >>> ohb_host_port.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Address bits 3:0 pick channel register.
// - Address bits 6:4 pick the channel.
// - Address bit 7 selects global registers.
// - Eight-bit two-way data bus.
// - Separate style: read strobe fall reads.
// - Separate style: write fall starts, rise latches.
// - Direction style: write pin high reads.
// - Direction style: chip select is strobe.
// - One shared open-drain interrupt output.
// - Receive input idles high.
// - Feature bit 4 inverts infrared receive.
// - Transmit pin carries normal or infrared.
// - Request-send: auto flow or half-duplex.
// - Terminal-ready: auto flow or half-duplex.
// - Clear-send gates transmit or general input.
// - Set-ready alternative gate or general input.
// - Carrier and ring readable as inputs.
// - All eight channels behave identically.

module ohb_host_port (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [ohb_pkg::AW-1:0] i_host_address_lines,
    input wire logic [ohb_pkg::DW-1:0] i_host_data_lines,
    output logic [ohb_pkg::DW-1:0] o_host_data_lines,
    output logic o_host_data_oe,
    input wire logic i_read_strobe_n,
    input wire logic i_write_strobe_n,
    input wire logic i_chip_select_n,
    input wire logic i_bus_style,
    output logic o_int_n_out,
    output logic o_int_n_oe,
    input wire logic [ohb_pkg::NCH-1:0] i_serial_in,
    input wire logic [ohb_pkg::NCH-1:0] i_clear_send_n,
    input wire logic [ohb_pkg::NCH-1:0] i_set_ready_n,
    input wire logic [ohb_pkg::NCH-1:0] i_carrier_detect_n,
    input wire logic [ohb_pkg::NCH-1:0] i_ring_indicate_n,
    input wire logic [ohb_pkg::NCH-1:0] i_tx_data,
    input wire logic [ohb_pkg::NCH-1:0] i_tx_ir,
    input wire logic [ohb_pkg::NCH-1:0] i_tx_busy,
    input wire logic [ohb_pkg::NCH-1:0] i_rx_stop,
    input wire logic [ohb_pkg::NCH-1:0] i_chan_irq,
    output logic [ohb_pkg::NCH-1:0] o_serial_out,
    output logic [ohb_pkg::NCH-1:0] o_request_send_n,
    output logic [ohb_pkg::NCH-1:0] o_terminal_ready_n,
    output logic [ohb_pkg::NCH-1:0] o_rx_line,
    output logic [ohb_pkg::NCH-1:0] o_tx_allow
);
    import ohb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Address field decoding shared by the read and write paths.
    function automatic logic [IDX_W-1:0] reg_idx(input logic [AW-1:0] a);
        reg_idx = a[IDX_LSB +: IDX_W];
    endfunction

    function automatic logic [CH_W-1:0] chan_num(input logic [AW-1:0] a);
        chan_num = a[CH_LSB +: CH_W];
    endfunction

    function automatic logic is_global(input logic [AW-1:0] a);
        is_global = a[GLB_BIT];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    logic [AW-1:0] addr_s;
    logic [DW-1:0] data_s;
    logic rd_s;
    logic wr_s;
    logic cs_s;
    logic style_s;
    logic [NCH-1:0] rx_s;
    logic [NCH-1:0] cts_s;
    logic [NCH-1:0] dsr_s;
    logic [NCH-1:0] cd_s;
    logic [NCH-1:0] ri_s;

    ohb_sync #(.W(AW), .RST('0)) u_sync_addr (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_async(i_host_address_lines),
        .o_sync(addr_s)
    );

    ohb_sync #(.W(DW), .RST('0)) u_sync_data (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_async(i_host_data_lines),
        .o_sync(data_s)
    );

    // Strobes reset to their inactive level so release never looks like an edge.
    ohb_sync #(.W(4), .RST(4'hF)) u_sync_ctl (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_async({i_read_strobe_n, i_write_strobe_n, i_chip_select_n, i_bus_style}),
        .o_sync({rd_s, wr_s, cs_s, style_s})
    );

    ohb_sync #(.W(5 * NCH), .RST('1)) u_sync_pins (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_async({i_serial_in, i_clear_send_n, i_set_ready_n, i_carrier_detect_n,
                  i_ring_indicate_n}),
        .o_sync({rx_s, cts_s, dsr_s, cd_s, ri_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on the synchronised strobes.
    logic rd_prev_q;
    logic wr_prev_q;
    logic cs_prev_q;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_prev_q <= 1'b1;
            wr_prev_q <= 1'b1;
            cs_prev_q <= 1'b1;
        end else if (i_ce) begin
            rd_prev_q <= rd_s;
            wr_prev_q <= wr_s;
            cs_prev_q <= cs_s;
        end
    end

    logic sep_style;
    logic rd_start;
    logic wr_start;
    logic strobe_rise;
    logic cs_fall;

    assign sep_style = style_s;
    assign cs_fall = cs_prev_q & ~cs_s;
    // Read strobe is ignored in direction style, so a host that ties it high is harmless.
    assign rd_start = sep_style ? (rd_prev_q & ~rd_s & ~cs_s)
                                : (cs_fall & wr_s);
    assign wr_start = sep_style ? (wr_prev_q & ~wr_s & ~cs_s)
                                : (cs_fall & ~wr_s);
    assign strobe_rise = sep_style ? (~wr_prev_q & wr_s)
                                   : (~cs_prev_q & cs_s);

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer.
    ohb_state_t state_q;
    logic [AW-1:0] cyc_addr_q;
    logic rd_end;

    // Dropping either qualifier ends a separate-style read, and chip select alone ends a direction-style one, so the bus is never left driven.
    assign rd_end = sep_style ? (rd_s | cs_s) : cs_s;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= OHB_IDLE;
            cyc_addr_q <= '0;
        end else if (i_ce) begin
            unique case (state_q)
                OHB_IDLE: begin
                    if (rd_start) begin
                        state_q <= OHB_READ;
                        cyc_addr_q <= addr_s;
                    end else if (wr_start) begin
                        state_q <= OHB_WRITE;
                        cyc_addr_q <= addr_s;
                    end
                end
                OHB_READ: begin
                    if (rd_end) begin
                        state_q <= OHB_IDLE;
                    end
                end
                OHB_WRITE: begin
                    if (strobe_rise) begin
                        state_q <= OHB_IDLE;
                    end
                end
                default: begin
                    state_q <= OHB_IDLE;
                end
            endcase
        end
    end

    logic wr_commit;
    logic rd_take;

    assign wr_commit = (state_q == OHB_WRITE) && strobe_rise;
    assign rd_take = (state_q == OHB_IDLE) && rd_start;

    ////////////////////////////////////////////////////////////////////////////
    // Register storage: one set of sixteen bytes per channel, plus the global scratch byte.
    logic [DW-1:0] regs_q [NCH][NREG];
    logic [DW-1:0] scratch_q;
    logic [IDX_W-1:0] w_idx;
    logic [CH_W-1:0] w_ch;
    logic chan_wr;
    logic glb_wr;

    assign w_idx = reg_idx(cyc_addr_q);
    assign w_ch = chan_num(cyc_addr_q);
    // The status byte is built from live pins, so a host write to it is dropped.
    assign chan_wr = wr_commit && !is_global(cyc_addr_q) && w_idx != IDX_MSR;
    assign glb_wr = wr_commit && is_global(cyc_addr_q) && w_idx == GIDX_SCRATCH;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int c = 0; c < NCH; c++) begin
                for (int r = 0; r < NREG; r++) begin
                    regs_q[c][r] <= REG_RST;
                end
            end
        end else if (i_ce && chan_wr) begin
            regs_q[w_ch][w_idx] <= data_s;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            scratch_q <= REG_RST;
        end else if (i_ce && glb_wr) begin
            scratch_q <= data_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channels.
    logic [7:0] modem_status_reg [NCH];
    logic [NCH-1:0] flow_evt;
    logic [NCH-1:0] msr_clr;
    logic [NCH-1:0] irq_pend;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_chan
            // Reading the status register of a channel clears its change flags.
            assign msr_clr[g] = rd_take && !is_global(addr_s)
                && chan_num(addr_s) == CH_W'(g) && reg_idx(addr_s) == IDX_MSR;
            assign irq_pend[g] = (i_chan_irq[g] & (regs_q[g][IDX_IER][3:0] != 4'h0))
                | flow_evt[g];

            ohb_chan u_chan (
                .i_clk(i_clk),
                .i_rst_b(i_rst_b),
                .i_ce(i_ce),
                .i_ier(regs_q[g][IDX_IER]),
                .i_mcr(regs_q[g][IDX_MCR]),
                .i_feature_control_reg(regs_q[g][IDX_FEATURE_CONTROL_REG]),
                .i_efr(regs_q[g][IDX_EFR]),
                .i_serial_in(rx_s[g]),
                .i_clear_send_n(cts_s[g]),
                .i_set_ready_n(dsr_s[g]),
                .i_carrier_detect_n(cd_s[g]),
                .i_ring_indicate_n(ri_s[g]),
                .i_tx_data(i_tx_data[g]),
                .i_tx_ir(i_tx_ir[g]),
                .i_tx_busy(i_tx_busy[g]),
                .i_rx_stop(i_rx_stop[g]),
                .i_msr_clr(msr_clr[g]),
                .o_serial_out(o_serial_out[g]),
                .o_request_send_n(o_request_send_n[g]),
                .o_terminal_ready_n(o_terminal_ready_n[g]),
                .o_rx_line(o_rx_line[g]),
                .o_tx_allow(o_tx_allow[g]),
                .o_flow_evt(flow_evt[g]),
                .o_msr(modem_status_reg[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read data path; the byte is captured once at the start of the cycle.
    logic [DW-1:0] rdata;
    logic [DW-1:0] rdata_q;
    logic oe_q;

    always_comb begin
        rdata = DATA_RST;
        if (is_global(addr_s)) begin
            unique case (reg_idx(addr_s))
                GIDX_IRQ: rdata = irq_pend;
                GIDX_SCRATCH: rdata = scratch_q;
                default: rdata = DATA_RST;
            endcase
        end else if (reg_idx(addr_s) == IDX_MSR) begin
            rdata = modem_status_reg[chan_num(addr_s)];
        end else begin
            rdata = regs_q[chan_num(addr_s)][reg_idx(addr_s)];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_q <= DATA_RST;
        end else if (i_ce && rd_take) begin
            rdata_q <= rdata;
        end
    end

    // The bus stays released except between read start and strobe release.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            oe_q <= 1'b0;
        end else if (i_ce) begin
            oe_q <= rd_take | ((state_q == OHB_READ) & ~rd_end);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared interrupt: the pin is only ever pulled low, never driven high.
    logic int_oe_q;
    logic int_lvl_q;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            int_oe_q <= 1'b0;
            int_lvl_q <= 1'b0;
        end else if (i_ce) begin
            int_oe_q <= |irq_pend;
            int_lvl_q <= 1'b0;
        end
    end

    assign o_host_data_lines = rdata_q;
    assign o_host_data_oe = oe_q;
    assign o_int_n_out = int_lvl_q;
    assign o_int_n_oe = int_oe_q;

endmodule

`default_nettype wire

// >>> ohb_host_port_chk.sv
`timescale 1ns/1ps
`default_nettype none

module ohb_host_port_chk (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_read_strobe_n,
    input wire logic i_write_strobe_n,
    input wire logic i_chip_select_n,
    input wire logic i_bus_style,
    input wire logic [ohb_pkg::DW-1:0] o_host_data_lines,
    input wire logic o_host_data_oe,
    input wire logic o_int_n_out,
    input wire logic [ohb_pkg::NCH-1:0] i_tx_data,
    input wire logic [ohb_pkg::NCH-1:0] i_tx_ir,
    input wire logic [ohb_pkg::NCH-1:0] i_clear_send_n,
    input wire logic [ohb_pkg::NCH-1:0] i_set_ready_n,
    input wire logic [ohb_pkg::NCH-1:0] o_serial_out,
    input wire logic [ohb_pkg::NCH-1:0] o_tx_allow
);
    import ohb_pkg::*;
    logic rd_req;
    logic wr_req;
    logic [NCH-1:0] pair_low;
    // Both styles share the write condition; only the read qualifier differs.
    assign rd_req = i_bus_style ? !(i_read_strobe_n | i_chip_select_n)
                                : (!i_chip_select_n && i_write_strobe_n);
    assign wr_req = !i_chip_select_n && !i_write_strobe_n;
    assign pair_low = ~(i_clear_send_n | i_set_ready_n);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    ////////////////////////////////////////
    sequence rd_start;
        !rd_req ##1 rd_req [*4];
    endsequence
    sequence rd_release;
        o_host_data_oe ##0 !rd_req [*3];
    endsequence

    a_int_low_drive: assert property (o_int_n_out == 1'b0)
        else $error("interrupt pin drives high");
    a_oe_rise_cause: assert property ($rose(o_host_data_oe) |-> $past(rd_req, 3))
        else $error("data bus driven without a read");
    a_oe_rise_timely: assert property (rd_start |-> o_host_data_oe)
        else $error("read data late");
    a_oe_release: assert property (rd_release |=> !o_host_data_oe)
        else $error("data bus held after read");
    a_oe_quiet_write: assert property (wr_req [*4] |-> !o_host_data_oe)
        else $error("data bus driven during write");
    a_read_byte_hold: assert property
        (o_host_data_oe && $past(o_host_data_oe) |-> $stable(o_host_data_lines))
        else $error("read byte changed while driven");
    a_tx_pin_source: assert property ($past(i_rst_b) |->
        ((o_serial_out ^ $past(i_tx_data)) & (o_serial_out ^ $past(i_tx_ir))) == '0)
        else $error("transmit pin from neither source");
    a_tx_allow_gate: assert property (($past(pair_low, 3) & ~o_tx_allow) == '0)
        else $error("transmit blocked with both gates low");
endmodule

bind ohb_host_port ohb_host_port_chk chk_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_read_strobe_n(i_read_strobe_n),
    .i_write_strobe_n(i_write_strobe_n), .i_chip_select_n(i_chip_select_n),
    .i_bus_style(i_bus_style), .o_host_data_lines(o_host_data_lines),
    .o_host_data_oe(o_host_data_oe), .o_int_n_out(o_int_n_out), .i_tx_data(i_tx_data),
    .i_tx_ir(i_tx_ir), .i_clear_send_n(i_clear_send_n), .i_set_ready_n(i_set_ready_n),
    .o_serial_out(o_serial_out), .o_tx_allow(o_tx_allow)
);

`default_nettype wire

// >>> ohb_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module ohb_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_dev_data,
    input wire logic i_dev_oe,
    output logic [7:0] o_addr,
    output logic [7:0] o_bus,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic o_cs_n,
    output logic o_style
);
    logic drv = 1'b0;
    logic [7:0] wdat = 8'h00;
    logic [7:0] last = 8'h00;

    initial begin
        o_addr = 8'h00;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_cs_n = 1'b1;
        o_style = 1'b1;
    end

    // A released bus flips every cycle, so a stale byte can never pass for data.
    assign o_bus = i_dev_oe ? i_dev_data : (drv ? wdat : ~last);
    always @(posedge i_clk) begin
        last <= o_bus;
    end

    ////////////////////////////////////////
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge i_clk);
        o_addr = a;
        wdat = d;
        drv = wr;
        if (o_style) o_cs_n = 1'b0;
        else o_wr_n = !wr;
        @(negedge i_clk);
        if (!o_style) o_cs_n = 1'b0;
        else if (wr) o_wr_n = 1'b0;
        else o_rd_n = 1'b0;
        repeat (4) @(posedge i_clk);
        while (!wr && i_dev_oe !== 1'b1 && n < 20) begin
            @(posedge i_clk);
            n++;
        end
        @(negedge i_clk);
        if (o_style) begin
            o_rd_n = 1'b1;
            o_wr_n = 1'b1;
        end else begin
            o_cs_n = 1'b1;
        end
        repeat (5) @(negedge i_clk);
        o_cs_n = 1'b1;
        drv = 1'b0;
    endtask
endmodule

`default_nettype wire

// >>> ohb_host_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module ohb_host_port_tb_top;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_ce = 1'b1;
    logic [7:0] addr, bus, dout, sin, cts_n, dsr_n, cd_n, ri_n, txd, txi, busy, stop, irq;
    logic [7:0] sout, rts_n, dtr_n, rxl, allow, r;
    logic [7:0] rv [8];
    logic oe, rd_n, wr_n, cs_n, style, int_n, int_oe;
    logic oe_q = 1'b0;
    logic [15:0] ev;
    logic [15:0] exp_q [$];
    int error_cnt = 0;
    int checks_done = 0;

    always #20 i_clk = ~i_clk;

    ohb_host_model host_u (.i_clk(i_clk), .i_dev_data(dout), .i_dev_oe(oe), .o_addr(addr),
        .o_bus(bus), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_cs_n(cs_n), .o_style(style));
    ohb_host_port dut_u (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_host_address_lines(addr),
        .i_host_data_lines(bus), .o_host_data_lines(dout), .o_host_data_oe(oe),
        .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .i_chip_select_n(cs_n),
        .i_bus_style(style), .o_int_n_out(int_n), .o_int_n_oe(int_oe),
        .i_serial_in(sin), .i_clear_send_n(cts_n), .i_set_ready_n(dsr_n),
        .i_carrier_detect_n(cd_n), .i_ring_indicate_n(ri_n), .i_tx_data(txd), .i_tx_ir(txi),
        .i_tx_busy(busy), .i_rx_stop(stop), .i_chan_irq(irq), .o_serial_out(sout),
        .o_request_send_n(rts_n), .o_terminal_ready_n(dtr_n), .o_rx_line(rxl),
        .o_tx_allow(allow));

    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({m, e});
        host_u.xfer(1'b0, a, 8'h00);
    endtask
    task automatic settle;
        repeat (4) @(negedge i_clk);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    always @(posedge i_clk) begin
        oe_q <= oe;
        if (oe === 1'b1 && oe_q === 1'b0) begin
            if (exp_q.size() == 0) chk("read count", 8'h00, 8'h01);
            ev = exp_q.pop_front();
            chk("read data", ev[7:0] & ev[15:8], dout & ev[15:8]);
        end
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        close_out();
    end

    initial begin
        {sin, cts_n, dsr_n, cd_n, ri_n} = {5{8'hFF}};
        {txd, txi, busy, stop, irq} = {5{8'h00}};
        void'($urandom(81));
        repeat (4) @(negedge i_clk);
        i_rst_b = 1'b1;
        settle();
        chk("rts", 8'hFF, rts_n);
        chk("dtr", 8'hFF, dtr_n);
        chk("rx line", 8'hFF, rxl);
        rd(8'h04, 8'h00, 8'hFF);
        $display("test reset done");
        for (int ch = 0; ch < 8; ch++) begin
            rv[ch] = 8'($urandom);
            wr({1'b0, 3'(ch), 4'h2}, rv[ch]);
            wr({1'b0, 3'(ch), 4'h3}, ~rv[ch]);
        end
        for (int ch = 0; ch < 8; ch++) begin
            rd({1'b0, 3'(ch), 4'h2}, rv[ch], 8'hFF);
            rd({1'b0, 3'(ch), 4'h3}, ~rv[ch], 8'hFF);
        end
        $display("test channels done");
        r = 8'($urandom);
        wr(8'h81, r);
        wr(8'h86, 8'h5A);
        rd(8'h81, r, 8'hFF);
        rd(8'h86, 8'h00, 8'hFF);
        rd(8'h01, 8'h00, 8'hFF);
        $display("test global done");
        host_u.o_style = 1'b0;
        settle();
        r = 8'($urandom);
        wr(8'h25, r);
        rd(8'h25, r, 8'hFF);
        host_u.o_style = 1'b1;
        settle();
        $display("test direction style done");
        wr(8'h34, 8'h03);
        settle();
        chk("rts", 8'hF7, rts_n);
        chk("dtr", 8'hF7, dtr_n);
        wr(8'h34, 8'h40);
        wr(8'h38, 8'h10);
        txd = 8'($urandom);
        txi = ~txd;
        sin = 8'($urandom);
        settle();
        chk("tx pin", (txd & 8'hF7) | (txi & 8'h08), sout);
        chk("rx line", sin ^ 8'h08, rxl);
        sin = 8'hFF;
        wr(8'h38, 8'h20);
        wr(8'h34, 8'h00);
        busy = 8'h08;
        settle();
        chk("rts", 8'hF7, rts_n);
        wr(8'h34, 8'h04);
        settle();
        chk("dtr", 8'hF7, dtr_n);
        chk("rts", 8'hFF, rts_n);
        busy = 8'h00;
        settle();
        chk("dtr", 8'hFF, dtr_n);
        $display("test pins done");
        wr(8'h38, 8'h00);
        wr(8'h39, 8'h80);
        wr(8'h34, 8'h00);
        dsr_n = 8'h00;
        settle();
        chk("allow", 8'hF7, allow);
        wr(8'h34, 8'h04);
        settle();
        chk("allow", 8'hFF, allow);
        dsr_n = 8'hFF;
        settle();
        chk("allow", 8'hF7, allow);
        wr(8'h39, 8'h40);
        wr(8'h34, 8'h02);
        settle();
        chk("rts", 8'hF7, rts_n);
        stop = 8'h08;
        settle();
        chk("rts", 8'hFF, rts_n);
        $display("test flow done");
        r = 8'($urandom) & 8'hFC;
        {cd_n[5], ri_n[5], dsr_n[5], cts_n[5]} = r[3:0];
        settle();
        rd(8'h56, {~r[3:0], ~r[3:0] | 4'h2}, 8'hFF);
        wr(8'h56, 8'h0F);
        rd(8'h56, {~r[3:0], 4'h0}, 8'hFF);
        $display("test status done");
        wr(8'h21, 8'h01);
        irq = 8'h04;
        settle();
        chk("int drive", 8'h01, {7'h00, int_oe});
        rd(8'h80, 8'h04, 8'hFF);
        wr(8'h21, 8'h00);
        settle();
        chk("int drive", 8'h00, {7'h00, int_oe});
        $display("test interrupt done");
        chk("reads left", 8'h00, 8'(exp_q.size()));
        close_out();
    end
endmodule

`default_nettype wire
